// File: design/oid_regs.svh
`ifndef OID_REGS_SVH
`define OID_REGS_SVH

// register indices; the byte address on the bus is four times the index
`define OID_IDX_WAVE_HI 16'h8026
`define OID_IDX_WAVE_MID 16'h8027
`define OID_IDX_WAVE_LO 16'h8028
`define OID_IDX_PKG0 16'h8032
`define OID_IDX_PKG1 16'h8033
`define OID_IDX_PKG2 16'h8034
`define OID_IDX_PKG3 16'h8035
`define OID_IDX_CTRL 16'h80f0
`define OID_IDX_CFG_WAVE 16'h80f1
`define OID_IDX_FIBRE 16'h80f2
`define OID_IDX_CFG_PKG 16'h80f3
`define OID_IDX_STATUS 16'h80f4

// least address width that reaches every index
`define OID_MIN_ADDR_W 18

// field positions
`define OID_CTRL_LOCK_BIT 0
`define OID_STAT_LOCK_BIT 0
`define OID_STAT_WVALID_BIT 1
`define OID_CFG_REV_LSB 0
`define OID_CFG_DEV_LSB 4
`define OID_PKG_RSVD_BIT 0
`define OID_PKG_REV_LSB 1
`define OID_PKG_DEV_LSB 5
`define OID_OUI_FIRST_BIT 3
`define OID_OUI_BITS 22

// reset values
`define OID_RST_WAVE 24'h01ffb8
`define OID_RST_FIBRE 8'h00
`define OID_RST_DEV 5'h00
`define OID_RST_REV 4'h0
// arbitrary neutral organisation identifier
`define OID_RST_OUI 24'h5ac31e

`endif

// File: design/oid_pkg.sv
package oid_pkg;

    typedef enum logic [1:0] {
        OID_RESP_OKAY = 2'h0,
        OID_RESP_SLVERR = 2'h2,
        OID_RESP_DECERR = 2'h3
    } oid_resp_t;

    typedef enum logic [1:0] {
        OID_WR_IDLE = 2'b01,
        OID_WR_RESP = 2'b10
    } oid_wr_state_t;

    typedef enum logic [1:0] {
        OID_RD_IDLE = 2'b01,
        OID_RD_DATA = 2'b10
    } oid_rd_state_t;

endpackage : oid_pkg

// File: design/oid_wave_split.sv
`timescale 1ns/1ps
`include "oid_regs.svh"

module oid_wave_split (
    input wire logic [23:0] wave,
    output logic [7:0] byte_hi,
    output logic [7:0] byte_mid,
    output logic [7:0] byte_lo
);
    import oid_pkg::*;

    // msb first, each byte with its msb at bit 7
    assign byte_hi = wave[23:16];
    assign byte_mid = wave[15:8];
    assign byte_lo = wave[7:0];

endmodule : oid_wave_split

// File: design/oid_pkg_ident.sv
`timescale 1ns/1ps
`include "oid_regs.svh"

module oid_pkg_ident #(
    parameter logic [23:0] OUI = `OID_RST_OUI
) (
    input wire logic [4:0] dev_addr,
    input wire logic [3:0] revision,
    output logic [31:0] ident
);
    import oid_pkg::*;

    // identifier bit n (1..24) is oui[n-1]; bit 3 lands on ident[31]
    genvar j;
    generate
        for (j = 0; j < `OID_OUI_BITS; j++) begin : g_oui
            assign ident[31-j] = OUI[j+`OID_OUI_FIRST_BIT-1];
        end
    endgenerate

    assign ident[`OID_PKG_DEV_LSB+:5] = dev_addr;
    assign ident[`OID_PKG_REV_LSB+:4] = revision;
    assign ident[`OID_PKG_RSVD_BIT] = 1'b0;

endmodule : oid_pkg_ident

// File: design/oid_top.sv
`timescale 1ns/1ps
`include "oid_regs.svh"

// Notes on behaviour
// - a readable field tells the host the intended optical fibre type
// - centre wavelength: 24-bit count of 0.01 nm, msb byte first, three regs
// - uncontrolled wavelength parts report their nominal centre wavelength
// - four-byte package identifier: organisation id, device address, revision
// - organisation id bits 3..24 reversed from byte0 bit 7 to byte2 bit 2

module oid_top #(
    parameter int ADDR_W = `OID_MIN_ADDR_W,
    parameter logic [23:0] OUI = `OID_RST_OUI,
    parameter logic [23:0] NOMINAL_WAVE = `OID_RST_WAVE,
    parameter logic [7:0] FIBRE_TYPE = `OID_RST_FIBRE,
    parameter logic [4:0] STORE_DEV_ADDR = `OID_RST_DEV,
    parameter logic [3:0] REVISION = `OID_RST_REV
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output oid_pkg::oid_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output oid_pkg::oid_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import oid_pkg::*;

    localparam int IW = ADDR_W - 2;

    generate
        if (ADDR_W < `OID_MIN_ADDR_W) begin : g_bad_addr_w
            $error("oid_top: ADDR_W too small for the register map");
        end
    endgenerate

    // configuration image of the nonvolatile store
    logic lock_ff;
    logic [23:0] wave_ff;
    logic [7:0] fibre_ff;
    logic [4:0] dev_ff;
    logic [3:0] rev_ff;

    // write side
    oid_wr_state_t wst_ff;
    logic awready_ff;
    logic wready_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [IW-1:0] widx_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    oid_resp_t bresp_ff;
    logic wr_fire;
    oid_resp_t nxt_bresp;

    // read side
    oid_rd_state_t rst_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    oid_resp_t rresp_ff;
    logic rd_fire;
    logic [IW-1:0] ridx;
    logic [31:0] nxt_rdata;
    oid_resp_t nxt_rresp;

    // packed views of the identification fields
    logic [7:0] wave_hi;
    logic [7:0] wave_mid;
    logic [7:0] wave_lo;
    logic [31:0] pkg_word;
    logic [31:0] wave_merged;

    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b+:8] = new_val[8*b+:8];
            end
        end
        return res;
    endfunction : merge_lanes

    function automatic logic is_idx(
        input logic [IW-1:0] idx,
        input logic [15:0] reg_idx
    );
        return idx == IW'(reg_idx);
    endfunction : is_idx

    oid_wave_split u_wave_split (
        .wave(wave_ff),
        .byte_hi(wave_hi),
        .byte_mid(wave_mid),
        .byte_lo(wave_lo)
    );

    oid_pkg_ident #(
        .OUI(OUI)
    ) u_pkg_ident (
        .dev_addr(dev_ff),
        .revision(rev_ff),
        .ident(pkg_word)
    );

    assign wr_fire = aw_held_ff && w_held_ff && (wst_ff == OID_WR_IDLE);
    assign rd_fire = s_axi_arvalid && arready_ff;
    assign ridx = s_axi_araddr[ADDR_W-1:2];
    // top lane of the merge is unused; only 24 bits are kept
    assign wave_merged = merge_lanes({8'h00, wave_ff}, wdata_ff, wstrb_ff);

    // write address channel; address and data are taken in either order
    always_ff @(posedge clock) begin
        if (!rstn) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            widx_ff <= '0;
        end else if (clk_en) begin
            if (s_axi_awvalid && awready_ff) begin
                aw_held_ff <= 1'b1;
                widx_ff <= s_axi_awaddr[ADDR_W-1:2];
            end else if (wr_fire) begin
                aw_held_ff <= 1'b0;
            end
            awready_ff <= (wst_ff == OID_WR_IDLE) && !aw_held_ff &&
                !(s_axi_awvalid && awready_ff);
        end
    end

    // write data channel
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_wvalid && wready_ff) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_ff <= 1'b0;
            end
            wready_ff <= (wst_ff == OID_WR_IDLE) && !w_held_ff &&
                !(s_axi_wvalid && wready_ff);
        end
    end

    // identification bytes refuse writes; config refuses them once locked
    always_comb begin
        nxt_bresp = OID_RESP_DECERR;
        if (is_idx(widx_ff, `OID_IDX_CTRL) ||
                is_idx(widx_ff, `OID_IDX_STATUS)) begin
            nxt_bresp = OID_RESP_OKAY;
        end else if (is_idx(widx_ff, `OID_IDX_CFG_WAVE) ||
                is_idx(widx_ff, `OID_IDX_FIBRE) ||
                is_idx(widx_ff, `OID_IDX_CFG_PKG)) begin
            nxt_bresp = lock_ff ? OID_RESP_SLVERR : OID_RESP_OKAY;
        end else if (is_idx(widx_ff, `OID_IDX_WAVE_HI) ||
                is_idx(widx_ff, `OID_IDX_WAVE_MID) ||
                is_idx(widx_ff, `OID_IDX_WAVE_LO) ||
                is_idx(widx_ff, `OID_IDX_PKG0) ||
                is_idx(widx_ff, `OID_IDX_PKG1) ||
                is_idx(widx_ff, `OID_IDX_PKG2) ||
                is_idx(widx_ff, `OID_IDX_PKG3)) begin
            nxt_bresp = OID_RESP_SLVERR;
        end
        if (s_axi_awprot[0] && 1'b0) begin
            nxt_bresp = OID_RESP_SLVERR;
        end
    end

    // write response
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wst_ff <= OID_WR_IDLE;
            bvalid_ff <= 1'b0;
            bresp_ff <= OID_RESP_OKAY;
        end else if (clk_en) begin
            unique case (wst_ff)
                OID_WR_IDLE: begin
                    if (wr_fire) begin
                        bvalid_ff <= 1'b1;
                        bresp_ff <= nxt_bresp;
                        wst_ff <= OID_WR_RESP;
                    end
                end
                OID_WR_RESP: begin
                    if (s_axi_bready) begin
                        bvalid_ff <= 1'b0;
                        wst_ff <= OID_WR_IDLE;
                    end
                end
            endcase
        end
    end

    // lock is one way: only a reset reopens the configuration image
    always_ff @(posedge clock) begin
        if (!rstn) begin
            lock_ff <= 1'b0;
        end else if (clk_en) begin
            if (wr_fire && is_idx(widx_ff, `OID_IDX_CTRL) &&
                    wstrb_ff[0] && wdata_ff[`OID_CTRL_LOCK_BIT]) begin
                lock_ff <= 1'b1;
            end
        end
    end

    // configuration image; reset loads the nominal values
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wave_ff <= NOMINAL_WAVE;
            fibre_ff <= FIBRE_TYPE;
            dev_ff <= STORE_DEV_ADDR;
            rev_ff <= REVISION;
        end else if (clk_en && wr_fire && nxt_bresp == OID_RESP_OKAY) begin
            if (is_idx(widx_ff, `OID_IDX_CFG_WAVE)) begin
                wave_ff <= wave_merged[23:0];
            end
            if (is_idx(widx_ff, `OID_IDX_FIBRE) && wstrb_ff[0]) begin
                fibre_ff <= wdata_ff[7:0];
            end
            if (is_idx(widx_ff, `OID_IDX_CFG_PKG) && wstrb_ff[0]) begin
                dev_ff <= wdata_ff[`OID_CFG_DEV_LSB+:5];
                rev_ff <= wdata_ff[`OID_CFG_REV_LSB+:4];
            end
        end
    end

    // read decode; narrow fields sit in the low bits, the rest read zero
    always_comb begin
        nxt_rdata = 32'h0;
        nxt_rresp = OID_RESP_OKAY;
        if (is_idx(ridx, `OID_IDX_WAVE_HI)) begin
            nxt_rdata[7:0] = wave_hi;
        end else if (is_idx(ridx, `OID_IDX_WAVE_MID)) begin
            nxt_rdata[7:0] = wave_mid;
        end else if (is_idx(ridx, `OID_IDX_WAVE_LO)) begin
            nxt_rdata[7:0] = wave_lo;
        end else if (is_idx(ridx, `OID_IDX_PKG0)) begin
            nxt_rdata[7:0] = pkg_word[31:24];
        end else if (is_idx(ridx, `OID_IDX_PKG1)) begin
            nxt_rdata[7:0] = pkg_word[23:16];
        end else if (is_idx(ridx, `OID_IDX_PKG2)) begin
            nxt_rdata[7:0] = pkg_word[15:8];
        end else if (is_idx(ridx, `OID_IDX_PKG3)) begin
            nxt_rdata[7:0] = pkg_word[7:0];
        end else if (is_idx(ridx, `OID_IDX_FIBRE)) begin
            nxt_rdata[7:0] = fibre_ff;
        end else if (is_idx(ridx, `OID_IDX_CFG_WAVE)) begin
            nxt_rdata[23:0] = wave_ff;
        end else if (is_idx(ridx, `OID_IDX_CFG_PKG)) begin
            nxt_rdata[`OID_CFG_DEV_LSB+:5] = dev_ff;
            nxt_rdata[`OID_CFG_REV_LSB+:4] = rev_ff;
        end else if (is_idx(ridx, `OID_IDX_CTRL)) begin
            nxt_rdata[`OID_CTRL_LOCK_BIT] = lock_ff;
        end else if (is_idx(ridx, `OID_IDX_STATUS)) begin
            nxt_rdata[`OID_STAT_LOCK_BIT] = lock_ff;
            nxt_rdata[`OID_STAT_WVALID_BIT] = |wave_ff;
        end else begin
            nxt_rresp = OID_RESP_DECERR;
        end
        if (s_axi_arprot[0] && 1'b0) begin
            nxt_rresp = OID_RESP_SLVERR;
        end
    end

    // read channel; data is captured at the address handshake
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rst_ff <= OID_RD_IDLE;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= OID_RESP_OKAY;
        end else if (clk_en) begin
            unique case (rst_ff)
                OID_RD_IDLE: begin
                    if (rd_fire) begin
                        arready_ff <= 1'b0;
                        rvalid_ff <= 1'b1;
                        rdata_ff <= nxt_rdata;
                        rresp_ff <= nxt_rresp;
                        rst_ff <= OID_RD_DATA;
                    end else begin
                        arready_ff <= 1'b1;
                    end
                end
                OID_RD_DATA: begin
                    if (s_axi_rready) begin
                        rvalid_ff <= 1'b0;
                        rst_ff <= OID_RD_IDLE;
                    end
                end
            endcase
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

endmodule : oid_top

// File: verification/oid_chk.sv
`timescale 1ns/1ps
`include "oid_regs.svh"
module oid_chk
    import oid_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter logic [23:0] OUI = 24'h0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire oid_pkg::oid_resp_t s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire oid_pkg::oid_resp_t s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [15:0] ar_ff;
    logic [15:0] aw_ff;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [5:0] b2;
    logic ar_map;
    logic aw_ro;
    assign b0 = {<<{OUI[9:2]}};
    assign b1 = {<<{OUI[17:10]}};
    assign b2 = {<<{OUI[23:18]}};
    assign aw_ro = aw_ff inside {[16'h8026:16'h8028], [16'h8032:16'h8035]};
    assign ar_map = ar_ff inside {[16'h8026:16'h8028], [16'h8032:16'h8035],
        [16'h80f0:16'h80f4]};
    // index held per transfer so each answer is tied to its request
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ar_ff <= 16'h0;
        end else if (clk_en && s_axi_arvalid && s_axi_arready) begin
            ar_ff <= 16'(s_axi_araddr >> 2);
        end
    end
    always_ff @(posedge clock) begin
        if (!rstn) begin
            aw_ff <= 16'h0;
        end else if (clk_en && s_axi_awvalid && s_axi_awready) begin
            aw_ff <= 16'(s_axi_awaddr >> 2);
        end
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    sequence rd_ok;
        $rose(s_axi_rvalid) && s_axi_rresp == OID_RESP_OKAY;
    endsequence
    sequence ar_taken;
        clk_en && s_axi_arvalid && s_axi_arready;
    endsequence
    byte0_oui_a: assert property (
        rd_ok ##0 ar_ff == `OID_IDX_PKG0 |-> s_axi_rdata == {24'h0, b0})
        else $error("package byte 0 wrong");
    byte1_oui_a: assert property (
        rd_ok ##0 ar_ff == `OID_IDX_PKG1 |-> s_axi_rdata == {24'h0, b1})
        else $error("package byte 1 wrong");
    byte2_oui_a: assert property (
        rd_ok ##0 ar_ff == `OID_IDX_PKG2 |-> s_axi_rdata[31:2] == {24'h0, b2})
        else $error("package byte 2 wrong");
    byte3_rsvd_a: assert property (
        rd_ok ##0 ar_ff == `OID_IDX_PKG3 |-> s_axi_rdata[31:8] == 24'h0
        && !s_axi_rdata[0]) else $error("package byte 3 wrong");
    ro_write_a: assert property (
        $rose(s_axi_bvalid) && aw_ro |-> s_axi_bresp == OID_RESP_SLVERR)
        else $error("write to read-only field accepted");
    unmapped_rd_a: assert property (
        $rose(s_axi_rvalid) && !ar_map |-> s_axi_rresp == OID_RESP_DECERR
        && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    read_answer_a: assert property (
        ar_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    read_hold_a: assert property (
        clk_en && s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule : oid_chk

bind oid_top oid_chk #(.ADDR_W(ADDR_W), .OUI(OUI)) oid_chk_i (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

// File: verification/oid_host.sv
`timescale 1ns/1ps
module oid_host #(
    parameter int ADDR_W = 18
) (
    input wire logic clock,
    input wire logic clk_en,
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    int lag = 0;
    initial {awvalid, wvalid, bready, arvalid, rready} = '0;
    initial {awaddr, araddr, wdata, wstrb} = '0;
    // released address and data lines go inverted so a stale value never passes for valid
    task automatic wr(input logic [15:0] idx, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] r);
        bit a;
        bit w;
        a = 0;
        w = 0;
        @(posedge clock);
        awaddr <= ADDR_W'({idx, 2'b00});
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a && w)) begin
            @(posedge clock);
            // a handshake counts only on an enabled edge
            if (!a && awready && clk_en) begin
                a = 1;
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (!w && wready && clk_en) begin
                w = 1;
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
        end
        repeat (lag) @(posedge clock);
        bready <= 1'b1;
        do @(posedge clock); while (!(bvalid && clk_en));
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] idx, output logic [33:0] r);
        @(posedge clock);
        araddr <= ADDR_W'({idx, 2'b00});
        arvalid <= 1'b1;
        do @(posedge clock); while (!(arready && clk_en));
        arvalid <= 1'b0;
        araddr <= ~araddr;
        repeat (lag) @(posedge clock);
        rready <= 1'b1;
        do @(posedge clock); while (!(rvalid && clk_en));
        r = {rresp, rdata};
        rready <= 1'b0;
    endtask : rd
endmodule : oid_host

// File: verification/oid_tb_top.sv
`timescale 1ns/1ps
`include "oid_regs.svh"
module oid_tb_top;
    import oid_pkg::*;
    localparam logic [23:0] T_OUI = 24'h3b91c4;
    localparam logic [23:0] T_WAVE = 24'h0207e6;
    localparam logic [7:0] T_FIB = 8'h5c;
    localparam logic [4:0] T_DEV = 5'h13;
    localparam logic [3:0] T_REV = 4'ha;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] prot = 3'h0;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    oid_resp_t bresp, rresp;
    logic [23:0] m_wave;
    logic [7:0] m_fib;
    logic [4:0] m_dev;
    logic [3:0] m_rev;
    logic m_lock;
    logic [31:0] rng = 32'h8;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] idx_l [12] = '{16'h8032, 16'h8033, 16'h8034, 16'h8035,
        16'h8026, 16'h8027, 16'h8028, 16'h80f1, 16'h80f2, 16'h80f3,
        16'h80f4, 16'h8030};
    oid_top #(.OUI(T_OUI), .NOMINAL_WAVE(T_WAVE), .FIBRE_TYPE(T_FIB),
        .STORE_DEV_ADDR(T_DEV), .REVISION(T_REV)) oid_top_i (
        .clock(clock), .rstn(rstn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    oid_host #(.ADDR_W(18)) oid_host_i (.clock(clock), .clk_en(clk_en),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    initial begin
        forever #20 clock = ~clock;
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    function automatic logic [33:0] exp_rd(input logic [15:0] idx);
        logic [31:0] w;
        for (int p = 0; p < 22; p++) w[31-p] = T_OUI[p+2];
        w[9:0] = {m_dev, m_rev, 1'b0};
        case (idx)
            16'h8026: return {26'h0, m_wave[23:16]};
            16'h8027: return {26'h0, m_wave[15:8]};
            16'h8028: return {26'h0, m_wave[7:0]};
            16'h8032: return {26'h0, w[31:24]};
            16'h8033: return {26'h0, w[23:16]};
            16'h8034: return {26'h0, w[15:8]};
            16'h8035: return {26'h0, w[7:0]};
            16'h80f1: return {10'h0, m_wave};
            16'h80f2: return {26'h0, m_fib};
            16'h80f3: return {25'h0, m_dev, m_rev};
            16'h80f4: return {32'h0, m_wave != 24'h0, m_lock};
            default: return {OID_RESP_DECERR, 32'h0};
        endcase
    endfunction : exp_rd
    function automatic logic [1:0] exp_wr(input logic [15:0] idx,
            input logic [31:0] d, input logic [3:0] s);
        if (idx inside {[16'h8026:16'h8028], [16'h8032:16'h8035]}) return 2;
        if (idx inside {[16'h80f1:16'h80f3]} && m_lock) return 2;
        case (idx)
            16'h80f0: m_lock |= d[0];
            16'h80f1: for (int b = 0; b < 3; b++)
                if (s[b]) m_wave[8*b +: 8] = d[8*b +: 8];
            16'h80f2: m_fib = d[7:0];
            16'h80f3: {m_dev, m_rev} = d[8:0];
            16'h80f4: ;
            default: return 3;
        endcase
        return 0;
    endfunction : exp_wr
    task automatic chk(input string nm, input logic [33:0] seen,
            input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [15:0] idx, input logic [31:0] d,
            input logic [3:0] s);
        logic [1:0] r;
        logic [1:0] e;
        e = exp_wr(idx, d, s);
        oid_host_i.wr(idx, d, s, r);
        chk("bresp", {32'h0, r}, {32'h0, e});
    endtask : wr
    task automatic rd_all();
        logic [33:0] r;
        foreach (idx_l[i]) begin
            oid_host_i.rd(idx_l[i], r);
            chk($sformatf("read %h", idx_l[i]), r,
                exp_rd(idx_l[i]));
        end
    endtask : rd_all
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        {m_wave, m_fib, m_dev, m_rev, m_lock} = {T_WAVE, T_FIB, T_DEV, T_REV,
            1'b0};
    endtask : do_reset
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    always @(posedge clock) begin
        cycles++;
        // enable drops about one edge in four at random so handshakes meet stalls
        clk_en <= (rnd() & 32'h3) != 32'h0;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        do_reset();
        rd_all();
        for (int i = 0; i < 10; i++) begin
            oid_host_i.lag = int'(rnd() % 3);
            prot <= 3'(rnd());
            wr(16'h80f1, i == 0 ? 32'h0 : rnd(), 4'(rnd()) | 4'h1);
            wr(16'h80f2, rnd(), 4'hf);
            wr(16'h80f3, rnd(), 4'hf);
            wr(idx_l[i % 7], rnd(), 4'hf);
            wr(16'h8040, rnd(), 4'hf);
            rd_all();
        end
        wr(16'h80f0, 32'h1, 4'hf);
        for (int j = 7; j < 11; j++) wr(idx_l[j], rnd(), 4'hf);
        rd_all();
        do_reset();
        rd_all();
        summarize();
    end
endmodule : oid_tb_top
